// *** src/uxs_top.sv ***
/*
  Serial port transmitter and receiver with mode, status/control, transmit,
  receive and baud divisor registers on APB.
  Assumes one clock pclk, synchronous serial_in_pin, and an outside pad that
  drives serial_out_pin only while serial_out_en is high.
*/
`timescale 1ns/1ps
module uxs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uxs_pkg::UXS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_en,
  output logic tx_event,
  output logic rx_event
);
  import uxs_pkg::*;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction
  function automatic logic par_bit(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic ir_en_ff, high_speed_baud_select_ff, stop_bit_select_ff, txpol_ff, brk_ff, txen_ff, address_detect_enable_ff, overrun_error_flag_ff;
  logic [1:0] parity_data_select_ff, txi_ff, rxi_ff;
  logic [15:0] brg_div_ff, brg_cnt_ff;
  logic [8:0] txq_ff [2];
  logic [1:0] tx_cnt_ff;
  uxs_tx_e tx_state_ff;
  logic [14:0] tx_sh_ff;
  logic [3:0] tx_bits_ff, tx_sub_ff;
  logic tx_brk_run_ff, txen_prev_ff, txen_pipe_ff, tx_event_ff;
  logic serial_out_pin_ff, serial_out_en_ff;
  logic [10:0] rxq_ff [2];
  logic [1:0] rx_cnt_ff;
  uxs_rx_e rx_state_ff;
  logic [3:0] rx_sub_ff, rx_idx_ff;
  logic [9:0] rx_sh_ff;
  logic ir_hold_ff, rx_pop_ok_ff, rx_event_ff;
  logic cap, acc, wr, wr_sta, mapped;
  logic tick, codec_on, nine, haspar, tx_push, tx_load, txen_clr, tx_done, txb, ir_pulse;
  logic [3:0] last_sub, mid_sub, rx_last_idx, tx_len;
  logic [14:0] tx_frame;
  logic rx_line, rx_samp, rx_fin, rx_keep, rx_push, ovf_set, overrun_error_flag_clr, rx_pop;
  logic [8:0] rx_d;
  logic rx_parity_error_flag;
  logic [15:0] mode_val, sta_val;
  logic [31:0] rd_val;
  // APB: capture one cycle into access, complete when pready is seen
  assign cap = psel & penable & ~pready_ff;
  assign acc = psel & penable & pready_ff;
  assign wr = acc & pwrite;
  assign wr_sta = wr & hit(paddr, UXS_STA_OFS);
  assign mapped = hit(paddr, UXS_MODE_OFS) | hit(paddr, UXS_STA_OFS) | hit(paddr, UXS_TXREG_OFS)
                  | hit(paddr, UXS_RXREG_OFS) | hit(paddr, UXS_BRG_OFS);
  assign codec_on = ir_en_ff & ~high_speed_baud_select_ff;
  assign last_sub = high_speed_baud_select_ff ? OVS_FAST_LAST : OVS_STD_LAST;
  assign mid_sub = {1'b0, last_sub[3:1]};
  assign nine = parity_data_select_ff == PD_9N;
  assign haspar = (parity_data_select_ff == PD_8O) | (parity_data_select_ff == PD_8E);
  assign tick = brg_cnt_ff == brg_div_ff;
  assign mode_val = {3'h0, ir_en_ff, 8'h00, high_speed_baud_select_ff, parity_data_select_ff, stop_bit_select_ff};
  assign sta_val = {txi_ff[1], txpol_ff, txi_ff[0], 1'b0, brk_ff, txen_ff,
                    tx_cnt_ff == TX_DEPTH,
                    tx_state_ff == UXS_TX_IDLE && tx_cnt_ff == 2'h0,
                    rxi_ff, address_detect_enable_ff,
                    rx_state_ff == UXS_RX_IDLE,
                    rx_cnt_ff != 2'h0 && rxq_ff[0][9],
                    rx_cnt_ff != 2'h0 && rxq_ff[0][10],
                    overrun_error_flag_ff,
                    rx_cnt_ff != 2'h0};
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit(paddr, UXS_MODE_OFS)) begin
      rd_val = {16'h0000, mode_val};
    end else if (hit(paddr, UXS_STA_OFS)) begin
      rd_val = {16'h0000, sta_val};
    end else if (hit(paddr, UXS_RXREG_OFS) && rx_cnt_ff != 2'h0) begin
      rd_val = {23'h000000, rxq_ff[0][8:0]};
    end else if (hit(paddr, UXS_BRG_OFS)) begin
      rd_val = {16'h0000, brg_div_ff};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      rx_pop_ok_ff <= 1'b0;
    end else begin
      pready_ff <= cap;
      pslverr_ff <= cap & ~mapped;
      if (cap && !pwrite) begin
        prdata_ff <= rd_val;
      end
      rx_pop_ok_ff <= cap & ~pwrite & hit(paddr, UXS_RXREG_OFS) & (rx_cnt_ff != 2'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_en_ff <= 1'b0;
      high_speed_baud_select_ff <= 1'b0;
      parity_data_select_ff <= PD_8N;
      stop_bit_select_ff <= 1'b0;
    end else if (wr && hit(paddr, UXS_MODE_OFS)) begin
      ir_en_ff <= pwdata[MODE_INFRARED_CODEC_ENABLE];
      high_speed_baud_select_ff <= pwdata[MODE_HIGH_SPEED_BAUD_SELECT];
      parity_data_select_ff <= pwdata[MODE_PARITY_DATA_SELECT +: 2];
      stop_bit_select_ff <= pwdata[MODE_STOP_BIT_SELECT];
    end
  end

  // Software write of send_break beats the hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txi_ff <= TXI_EACH;
      rxi_ff <= RXI_ANY;
      txpol_ff <= 1'b0;
      brk_ff <= 1'b0;
      txen_ff <= 1'b0;
      address_detect_enable_ff <= 1'b0;
    end else if (wr_sta) begin
      txi_ff <= {pwdata[STA_TXI1], pwdata[STA_TXI0]};
      rxi_ff <= pwdata[STA_RXI +: 2];
      txpol_ff <= pwdata[STA_TXPOL];
      brk_ff <= pwdata[STA_BRK];
      txen_ff <= pwdata[STA_TXEN];
      address_detect_enable_ff <= pwdata[STA_ADDRESS_DETECT_ENABLE];
    end else if (tx_done && tx_brk_run_ff) begin
      brk_ff <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brg_div_ff <= BRG_RST;
      brg_cnt_ff <= 16'h0000;
    end else begin
      if (wr && hit(paddr, UXS_BRG_OFS)) begin
        brg_div_ff <= pwdata[15:0];
      end
      if ((wr && hit(paddr, UXS_BRG_OFS)) || tick) begin
        brg_cnt_ff <= 16'h0000;
      end else begin
        brg_cnt_ff <= brg_cnt_ff + 16'h0001;
      end
    end
  end
  // Transmit buffer: entry 0 is the head
  assign txen_clr = wr_sta & ~pwdata[STA_TXEN];
  assign tx_push = wr & hit(paddr, UXS_TXREG_OFS) & (tx_cnt_ff != TX_DEPTH);
  assign tx_load = txen_ff & ~txen_clr & (tx_state_ff == UXS_TX_IDLE) & (tx_cnt_ff != 2'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_ff <= 2'h0;
      txq_ff[0] <= 9'h000;
      txq_ff[1] <= 9'h000;
    end else if (txen_clr) begin
      tx_cnt_ff <= 2'h0;
    end else if (tx_push && tx_load) begin
      txq_ff[0] <= (tx_cnt_ff == 2'h1) ? pwdata[8:0] : txq_ff[1];
      txq_ff[1] <= pwdata[8:0];
    end else if (tx_push) begin
      txq_ff[tx_cnt_ff[0]] <= pwdata[8:0];
      tx_cnt_ff <= tx_cnt_ff + 2'h1;
    end else if (tx_load) begin
      txq_ff[0] <= txq_ff[1];
      tx_cnt_ff <= tx_cnt_ff - 2'h1;
    end
  end
  // Frame bits go out LSB first; unused upper bits are stop level
  always_comb begin
    tx_frame = {6'h3f, txq_ff[0][7:0], 1'b0};
    tx_len = 4'ha;
    if (brk_ff) begin
      tx_frame = {2'b11, 13'h0000};
      tx_len = BRK_FRAME_LEN;
    end else if (nine) begin
      tx_frame = {5'h1f, txq_ff[0], 1'b0};
      tx_len = 4'hb;
    end else if (haspar) begin
      tx_frame = {5'h1f, par_bit(txq_ff[0][7:0], parity_data_select_ff == PD_8O), txq_ff[0][7:0], 1'b0};
      tx_len = 4'hb;
    end
    if (stop_bit_select_ff && !brk_ff) begin
      tx_len = tx_len + 4'h1;
    end
  end
  assign tx_done = (tx_state_ff == UXS_TX_SHIFT) & tick & (tx_sub_ff == last_sub) & (tx_bits_ff == 4'h1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_ff <= UXS_TX_IDLE;
      tx_sh_ff <= 15'h7fff;
      tx_bits_ff <= 4'h0;
      tx_sub_ff <= 4'h0;
      tx_brk_run_ff <= 1'b0;
    end else if (txen_clr) begin
      tx_state_ff <= UXS_TX_IDLE;
      tx_sh_ff <= 15'h7fff;
    end else if (tx_load) begin
      tx_state_ff <= UXS_TX_SHIFT;
      tx_sh_ff <= tx_frame;
      tx_bits_ff <= tx_len;
      tx_sub_ff <= 4'h0;
      tx_brk_run_ff <= brk_ff;
    end else if (tx_state_ff == UXS_TX_SHIFT && tick) begin
      if (tx_sub_ff == last_sub) begin
        tx_sub_ff <= 4'h0;
        tx_sh_ff <= {1'b1, tx_sh_ff[14:1]};
        tx_bits_ff <= tx_bits_ff - 4'h1;
        if (tx_bits_ff == 4'h1) begin
          tx_state_ff <= UXS_TX_IDLE;
        end
      end else begin
        tx_sub_ff <= tx_sub_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txen_prev_ff <= 1'b0;
      txen_pipe_ff <= 1'b0;
      tx_event_ff <= 1'b0;
    end else begin
      txen_prev_ff <= txen_ff;
      txen_pipe_ff <= txen_ff & ~txen_prev_ff;
      tx_event_ff <= txen_pipe_ff
                     | (tx_load && txi_ff == TXI_EACH)
                     | (tx_load && txi_ff == TXI_EMPTY && tx_cnt_ff == 2'h1)
                     | (tx_done && txi_ff == TXI_DONE && tx_cnt_ff == 2'h0 && !tx_push);
    end
  end

  assign txb = (tx_state_ff == UXS_TX_SHIFT) ? tx_sh_ff[0] : 1'b1;
  // Encoder marks each zero bit with a pulse of 3/16 bit time
  assign ir_pulse = codec_on & ~txb & (tx_sub_ff < IR_PULSE_SUBS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin_ff <= 1'b1;
      serial_out_en_ff <= 1'b0;
    end else begin
      serial_out_pin_ff <= codec_on ? (ir_pulse ^ txpol_ff) : (txb ^ txpol_ff);
      serial_out_en_ff <= txen_ff;
    end
  end

  // Receiver: decoder stretches a pulse until the next mid-bit sample
  assign rx_line = codec_on ? ~ir_hold_ff : serial_in_pin;
  assign rx_samp = (rx_state_ff == UXS_RX_RUN) & tick & (rx_sub_ff == mid_sub);
  assign rx_last_idx = (nine || haspar) ? 4'ha : 4'h9;
  assign rx_fin = rx_samp & (rx_idx_ff == rx_last_idx);
  assign rx_d = nine ? rx_sh_ff[9:1] : {1'b0, haspar ? rx_sh_ff[8:1] : rx_sh_ff[9:2]};
  assign rx_parity_error_flag = haspar & (rx_sh_ff[9] != par_bit(rx_sh_ff[8:1], parity_data_select_ff == PD_8O));
  assign rx_keep = ~(address_detect_enable_ff & nine & ~rx_d[8]);
  assign ovf_set = rx_fin & rx_keep & (rx_cnt_ff == RX_DEPTH);
  assign rx_push = rx_fin & rx_keep & (rx_cnt_ff != RX_DEPTH);
  assign overrun_error_flag_clr = wr_sta & overrun_error_flag_ff & ~pwdata[STA_OVERRUN_ERROR_FLAG] & ~ovf_set;
  assign rx_pop = acc & ~pwrite & rx_pop_ok_ff & (rx_cnt_ff != 2'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_hold_ff <= 1'b0;
    end else if (codec_on && serial_in_pin) begin
      ir_hold_ff <= 1'b1;
    end else if (rx_samp || !codec_on) begin
      ir_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_ff <= UXS_RX_IDLE;
      rx_sub_ff <= 4'h0;
      rx_idx_ff <= 4'h0;
      rx_sh_ff <= 10'h000;
    end else if (overrun_error_flag_clr) begin
      rx_state_ff <= UXS_RX_IDLE;
    end else if (rx_state_ff == UXS_RX_IDLE) begin
      if (tick && !rx_line) begin
        rx_state_ff <= UXS_RX_RUN;
        rx_sub_ff <= 4'h0;
        rx_idx_ff <= 4'h0;
      end
    end else if (tick) begin
      rx_sub_ff <= (rx_sub_ff == last_sub) ? 4'h0 : rx_sub_ff + 4'h1;
      if (rx_sub_ff == last_sub) begin
        rx_idx_ff <= rx_idx_ff + 4'h1;
      end
      if (rx_samp) begin
        if ((rx_idx_ff == 4'h0 && rx_line) || rx_fin) begin
          rx_state_ff <= UXS_RX_IDLE;
        end else if (rx_idx_ff != 4'h0) begin
          rx_sh_ff <= {rx_line, rx_sh_ff[9:1]};
        end
      end
    end
  end

  // Overflow set beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error_flag_ff <= 1'b0;
    end else if (ovf_set) begin
      overrun_error_flag_ff <= 1'b1;
    end else if (overrun_error_flag_clr) begin
      overrun_error_flag_ff <= 1'b0;
    end
  end
  // Entry holds {framing, parity, data}; the overflowing character is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_ff <= 2'h0;
      rxq_ff[0] <= 11'h000;
      rxq_ff[1] <= 11'h000;
    end else if (overrun_error_flag_clr) begin
      rx_cnt_ff <= 2'h0;
    end else if (rx_push && rx_pop) begin
      rxq_ff[0] <= (rx_cnt_ff == 2'h1) ? {~rx_line, rx_parity_error_flag, rx_d} : rxq_ff[1];
      rxq_ff[1] <= {~rx_line, rx_parity_error_flag, rx_d};
    end else if (rx_push) begin
      rxq_ff[rx_cnt_ff[0]] <= {~rx_line, rx_parity_error_flag, rx_d};
      rx_cnt_ff <= rx_cnt_ff + 2'h1;
    end else if (rx_pop) begin
      rxq_ff[0] <= rxq_ff[1];
      rx_cnt_ff <= rx_cnt_ff - 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_event_ff <= 1'b0;
    end else begin
      rx_event_ff <= rx_push & ~overrun_error_flag_clr & ((rxi_ff == RXI_ANY) | (rxi_ff == RXI_FULL && rx_cnt_ff == 2'h1));
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign serial_out_pin = serial_out_pin_ff;
  assign serial_out_en = serial_out_en_ff;
  assign tx_event = tx_event_ff;
  assign rx_event = rx_event_ff;
  a_txen_event: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(txen_ff) |-> ##2 tx_event_ff) else $error("tx enable event not two cycles later");
  a_tx_each_evt: assert property (@(posedge pclk) disable iff (!presetn)
    tx_load && txi_ff == TXI_EACH |=> tx_event_ff) else $error("missing tx load event");
  a_txen_abort: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(txen_ff) |-> tx_cnt_ff == 2'h0 && tx_state_ff == UXS_TX_IDLE ##1 !serial_out_en_ff)
    else $error("tx disable did not abort");
  a_tx_busy_flag: assert property (@(posedge pclk) disable iff (!presetn)
    tx_load |=> !sta_val[STA_SHEMPTY] && tx_state_ff == UXS_TX_SHIFT) else $error("shift empty wrong");
  a_brg_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, UXS_BRG_OFS) |=> brg_cnt_ff == 16'h0000) else $error("baud counter not cleared");
  a_ir_fast_off: assert property (@(posedge pclk) disable iff (!presetn)
    high_speed_baud_select_ff |-> !ir_pulse ##1 !ir_hold_ff && serial_out_pin_ff == ($past(txb) ^ $past(txpol_ff)))
    else $error("codec active in fast mode");
  a_rx_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_set |=> overrun_error_flag_ff && rx_cnt_ff == RX_DEPTH) else $error("overrun not flagged");
  a_overrun_error_flag_flush: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_error_flag_clr |=> rx_cnt_ff == 2'h0 && !overrun_error_flag_ff && rx_state_ff == UXS_RX_IDLE) else $error("no flush");
  a_rx_evt_full: assert property (@(posedge pclk) disable iff (!presetn)
    rx_push && !overrun_error_flag_clr && rxi_ff == RXI_FULL |=> rx_event_ff == (rx_cnt_ff == RX_DEPTH))
    else $error("rx full event wrong");
  a_rx_avail: assert property (@(posedge pclk) disable iff (!presetn)
    rx_push && !overrun_error_flag_clr |=> sta_val[STA_RXDA]) else $error("data available not set");
endmodule

// *** src/uxs_pkg.sv ***
/*
  Shared constants for the serial port block: register offsets, field positions,
  frame and interrupt mode codes, oversampling and buffer sizes.
  Assumes a 32-bit APB slave with byte addresses in an 8-bit window.
*/
package uxs_pkg;
  localparam int UXS_AW = 8;
  localparam logic [7:0] UXS_MODE_OFS = 8'h00;
  localparam logic [7:0] UXS_STA_OFS = 8'h04;
  localparam logic [7:0] UXS_TXREG_OFS = 8'h08;
  localparam logic [7:0] UXS_RXREG_OFS = 8'h0c;
  localparam logic [7:0] UXS_BRG_OFS = 8'h10;
  // Mode register fields
  localparam int MODE_INFRARED_CODEC_ENABLE = 12;
  localparam int MODE_HIGH_SPEED_BAUD_SELECT = 3;
  localparam int MODE_PARITY_DATA_SELECT = 1;
  localparam int MODE_STOP_BIT_SELECT = 0;
  // Status and control register fields
  localparam int STA_TXI1 = 15;
  localparam int STA_TXPOL = 14;
  localparam int STA_TXI0 = 13;
  localparam int STA_BRK = 11;
  localparam int STA_TXEN = 10;
  localparam int STA_TXFULL = 9;
  localparam int STA_SHEMPTY = 8;
  localparam int STA_RXI = 6;
  localparam int STA_ADDRESS_DETECT_ENABLE = 5;
  localparam int STA_RXIDLE = 4;
  localparam int STA_PARITY_ERROR_FLAG = 3;
  localparam int STA_FRAMING_ERROR_FLAG = 2;
  localparam int STA_OVERRUN_ERROR_FLAG = 1;
  localparam int STA_RXDA = 0;
  localparam logic [15:0] BRG_RST = 16'h0000;
  // Frame formats
  localparam logic [1:0] PD_9N = 2'b11;
  localparam logic [1:0] PD_8O = 2'b10;
  localparam logic [1:0] PD_8E = 2'b01;
  localparam logic [1:0] PD_8N = 2'b00;
  // Interrupt modes
  localparam logic [1:0] TXI_EACH = 2'b00;
  localparam logic [1:0] TXI_DONE = 2'b01;
  localparam logic [1:0] TXI_EMPTY = 2'b10;
  localparam logic [1:0] RXI_ANY = 2'b00;
  localparam logic [1:0] RXI_FULL = 2'b11;
  // Oversampling: last subtick index of 16x and 4x
  localparam logic [3:0] OVS_STD_LAST = 4'hf;
  localparam logic [3:0] OVS_FAST_LAST = 4'h3;
  localparam logic [3:0] IR_PULSE_SUBS = 4'h3;
  localparam logic [3:0] BRK_FRAME_LEN = 4'he;
  localparam logic [1:0] TX_DEPTH = 2'h2;
  localparam logic [1:0] RX_DEPTH = 2'h2;
  localparam int TXEN_IRQ_CYC = 2;
  typedef enum logic {UXS_TX_IDLE, UXS_TX_SHIFT} uxs_tx_e;
  typedef enum logic {UXS_RX_IDLE, UXS_RX_RUN} uxs_rx_e;
endpackage

// *** verification/uxs_peer.sv ***
/*
  Remote serial device model: sends frames into the receiver and decodes
  frames from the transmitter. Assumes an idle-high line with the codec off.
*/
`timescale 1ns/1ps
module uxs_peer (
  input wire logic pclk,
  input wire logic serial_out_pin,
  output logic serial_in_pin
);
  initial serial_in_pin = 1'b1;

  // Parity code pm: 0 none, 1 even, 2 odd
  task automatic send(input logic [8:0] d, input int nb, input int pm, input int bp, input bit bad_par,
                      input bit bad_stop);
    logic [12:0] f;
    int n;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[i + 1] = d[i];
    n = nb + 1;
    if (pm != 0) begin
      f[n] = ((pm == 2) ? ~^d[7:0] : ^d[7:0]) ^ bad_par;
      n = n + 1;
    end
    f[n] = ~bad_stop;
    n = n + 1;
    // One extra idle bit closes the frame
    for (int i = 0; i <= n; i++) begin
      serial_in_pin <= f[i];
      repeat (bp) @(posedge pclk);
    end
  endtask

  task automatic recv(input int bp, input int nb, input int pm, input int ns, output logic [8:0] d,
                      output bit ok);
    d = '0;
    while (serial_out_pin !== 1'b0) @(posedge pclk);
    repeat (bp / 2) @(posedge pclk);
    ok = (serial_out_pin === 1'b0);
    for (int i = 0; i < nb; i++) begin
      repeat (bp) @(posedge pclk);
      d[i] = serial_out_pin;
    end
    if (pm != 0) begin
      repeat (bp) @(posedge pclk);
      ok &= (serial_out_pin === ((pm == 2) ? ~^d[7:0] : ^d[7:0]));
    end
    for (int i = 0; i < ns; i++) begin
      repeat (bp) @(posedge pclk);
      ok &= (serial_out_pin === 1'b1);
    end
  endtask

  task automatic lowrun(output int n);
    while (serial_out_pin !== 1'b0) @(posedge pclk);
    n = 0;
    while (serial_out_pin === 1'b0) begin
      @(posedge pclk);
      n++;
    end
  endtask
endmodule

// *** verification/uxs_top_tb.sv ***
/*
  Self-checking bench for the serial port: APB master tasks, event counters,
  and the peer model on the pins. Assumes the register map of uxs_pkg.
*/
`timescale 1ns/1ps
module uxs_top_tb;
  import uxs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic serial_in_pin, serial_out_pin, serial_out_en, tx_event, rx_event;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] v;
  logic [8:0] d [3];
  logic [8:0] q;
  logic [1:0] mc;
  int err_count, total_checks, ntx, nrx, seed, n;
  bit ok;

  uxs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_en(serial_out_en),
    .tx_event(tx_event), .rx_event(rx_event));
  uxs_peer peer (.pclk(pclk), .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (tx_event === 1'b1) ntx++;
    if (rx_event === 1'b1) nrx++;
  end

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [15:0] wd, output logic [15:0] r, output logic se);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata[15:0];
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so no signal is driven twice at one edge
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [15:0] wd);
    logic [15:0] r;
    logic se;
    apb(1'b1, a, wd, r, se);
  endtask

  task rd(input logic [7:0] a, output logic [15:0] r);
    logic se;
    apb(1'b0, a, 16'h0, r, se);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    end_sim;
  end

  initial begin
    seed = 32'hf2c1;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(UXS_STA_OFS, v);
    chk("sta reset", 16'h0110, v);
    rd(UXS_MODE_OFS, v);
    chk("mode reset", 16'h0000, v);
    apb(1'b0, 8'h14, 16'h0, v, e);
    chk("unmapped err", 1'b1, e);
    $display("test reset done");
    ntx = 0;
    wr(UXS_STA_OFS, 16'h0400);
    repeat (3) @(posedge pclk);
    chk("enable event", 1, ntx);
    chk("pin owner", 1'b1, serial_out_en);
    for (int k = 0; k < 8; k++) begin
      int pd, st, fs, bp, nb, m;
      pd = k % 4;
      st = k / 4;
      fs = (k / 2) % 2 ^ st;
      bp = fs ? 4 : 16;
      nb = (pd == 3) ? 9 : 8;
      m = k % 3;
      mc = (m == 0) ? TXI_EACH : (m == 1) ? TXI_EMPTY : TXI_DONE;
      wr(UXS_MODE_OFS, 16'(fs * 8 + pd * 2 + st));
      wr(UXS_STA_OFS, {mc[1], 1'b0, mc[0], 3'b001, 10'h0});
      repeat (4) @(posedge pclk);
      ntx = 0;
      for (int i = 0; i < 3; i++) d[i] = 9'($random(seed)) & ((nb == 9) ? 9'h1ff : 9'h0ff);
      fork
        begin
          for (int i = 0; i < 3; i++) wr(UXS_TXREG_OFS, {7'h0, d[i]});
          rd(UXS_STA_OFS, v);
          chk("tx full", 2'b10, v[9:8]);
        end
        for (int i = 0; i < 3; i++) begin
          peer.recv(bp, nb, pd % 3, st + 1, q, ok);
          chk("tx data", d[i], q);
          chk("tx frame", 1'b1, ok);
        end
      join
      repeat (2 * bp) @(posedge pclk);
      chk("tx events", 3 - m, ntx);
    end
    $display("test transmit done");
    wr(UXS_STA_OFS, 16'h4400);
    // Pin is launched one edge after the write lands
    @(posedge pclk);
    chk("idle inverted", 1'b0, serial_out_pin);
    wr(UXS_MODE_OFS, 16'h1000);
    @(posedge pclk);
    chk("idle codec", 1'b1, serial_out_pin);
    wr(UXS_MODE_OFS, 16'h0000);
    wr(UXS_STA_OFS, 16'h0400);
    for (int i = 0; i < 3; i++) wr(UXS_TXREG_OFS, 16'($random(seed)) & 16'h00ff);
    wr(UXS_STA_OFS, 16'h0000);
    rd(UXS_STA_OFS, v);
    chk("flushed", 16'h0110, v);
    chk("pin released", 1'b0, serial_out_en);
    wr(UXS_MODE_OFS, 16'h0008);
    wr(UXS_STA_OFS, 16'h0c00);
    wr(UXS_TXREG_OFS, 16'h00a5);
    peer.lowrun(n);
    chk("break length", 13 * 4, n);
    repeat (12) @(posedge pclk);
    rd(UXS_STA_OFS, v);
    chk("break cleared", 1'b0, v[11]);
    $display("test abort and break done");
    wr(UXS_STA_OFS, 16'h0000);
    wr(UXS_MODE_OFS, 16'h000a);
    nrx = 0;
    for (int i = 0; i < 3; i++) d[i] = 9'($random(seed)) & 9'h0ff;
    fork
      peer.send(d[0], 8, 1, 4, 1'b0, 1'b0);
      begin
        repeat (12) @(posedge pclk);
        rd(UXS_STA_OFS, v);
        chk("rx busy", 1'b0, v[4]);
      end
    join
    peer.send(d[1], 8, 1, 4, 1'b1, 1'b0);
    rd(UXS_STA_OFS, v);
    chk("rx head", 16'h0111, v);
    rd(UXS_RXREG_OFS, v);
    chk("rx first", d[0], v);
    rd(UXS_STA_OFS, v);
    chk("rx parity", 16'h0119, v);
    rd(UXS_RXREG_OFS, v);
    chk("rx second", d[1], v);
    chk("rx events", 2, nrx);
    peer.send(d[2], 8, 1, 4, 1'b0, 1'b1);
    rd(UXS_STA_OFS, v);
    chk("rx framing", 16'h0115, v);
    rd(UXS_RXREG_OFS, v);
    rd(UXS_STA_OFS, v);
    chk("rx empty", 16'h0110, v);
    wr(UXS_STA_OFS, 16'h00c0);
    nrx = 0;
    for (int i = 0; i < 3; i++) peer.send(d[i], 8, 1, 4, 1'b0, 1'b0);
    chk("rx full event", 1, nrx);
    rd(UXS_STA_OFS, v);
    chk("overrun set", 16'h01d3, v);
    wr(UXS_STA_OFS, 16'h00c0);
    rd(UXS_STA_OFS, v);
    chk("overrun flush", 16'h01d0, v);
    wr(UXS_MODE_OFS, 16'h000e);
    wr(UXS_STA_OFS, 16'h0020);
    peer.send(d[0] & 9'h0ff, 9, 0, 4, 1'b0, 1'b0);
    peer.send(d[1] | 9'h100, 9, 0, 4, 1'b0, 1'b0);
    rd(UXS_RXREG_OFS, v);
    chk("address kept", d[1] | 9'h100, v);
    rd(UXS_STA_OFS, v);
    chk("data dropped", 1'b0, v[0]);
    // Divisor 1: one tick every two clocks, so eight clocks per bit
    wr(UXS_BRG_OFS, 16'h0001);
    rd(UXS_BRG_OFS, v);
    chk("divisor", 16'h0001, v);
    peer.send(d[2] | 9'h100, 9, 0, 8, 1'b0, 1'b0);
    rd(UXS_RXREG_OFS, v);
    chk("slow rate data", d[2] | 9'h100, v);
    $display("test receive done");
    end_sim;
  end
endmodule
